// file: hw/dacseq_host.sv
/*
  Host-side power sequencer for a pin-configured stereo audio DAC.
  Drives reset, static configuration pins and the master, bit and frame
  clocks, and mutes the audio source for the shutdown zero run.
  Software sees four word registers: control, configuration, status
  and clock divider; configuration and dividers change only while off.
  Every output toward the device comes from a flip-flop.
  Assumes supplies are up before software starts a power-up and that
  the audio source honours the mute output on frame boundaries.
*/
// Local design decisions: the register offsets and register access over AXI4-Lite.
// Summary of operation
// - Hold reset low while supplies ramp
// - Set configuration pins before starting device
// - Clocks running and locked before reset release
// - Raise reset only after clocks stable
// - Power-on-reset path keeps reset high
// - POR path starts clocks after config stable
// - Send 8192 zero frames before shutdown
// - Reset low after zero run on reset path
// - Stop master clock cleanly on POR path
// - Never emit a short master clock pulse
`timescale 1ns/1ps
`default_nettype none
module dacseq_host #(
  parameter longint STARTUP_CYC = dacseq_pkg::DACSEQ_STARTUP_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic dac_reset_n,
  output dacseq_pkg::dacseq_cfg_t dac_cfg,
  output dacseq_pkg::dacseq_clk_t dac_clk,
  output logic audio_mute,
  output logic audio_valid
);

  // Sequencer state
  dacseq_pkg::dacseq_state_t state;
  dacseq_pkg::dacseq_state_t next_state;

  // Software-held registers
  logic por_mode; // Internal power-on reset path chosen
  dacseq_pkg::dacseq_cfg_t cfg; // Pending configuration levels
  logic [7:0] bclk_half; // Master clocks per bit clock half period
  logic [7:0] frame_half; // Bit clocks per frame half period
  logic up_req; // Power-up request pulse
  logic down_req; // Power-down request pulse

  // Clock generation state
  logic clk_run; // Clocks enabled
  logic mclk; // Master clock divider output
  logic [7:0] bdiv; // Bit clock divider counter
  logic bclk;
  logic [7:0] fdiv; // Frame clock divider counter
  logic fclk;

  // Timers
  logic [31:0] timer; // Settle and latency counter
  logic [13:0] zero_cnt; // Zero frames sent

  // AXI holding registers
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Edge enables: master clock falls on the next edge whenever it is high
  wire mclk_fall = mclk;
  // Bit clock toggles once per bclk_half master periods
  wire bit_tick = clk_run && mclk_fall && (bdiv == bclk_half - 8'h01);
  // Bit clock falling edge steps the frame divider
  wire bclk_fall = bit_tick && bclk;
  // Frame clock toggles once per frame_half bit periods
  wire frame_tick = bclk_fall && (fdiv == frame_half - 8'h01);
  // Counted once per frame by the zero run
  wire frame_start = frame_tick && fclk; // Frame clock falls: new frame

  // Write decode
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl = wr_go && (aw_addr == dacseq_pkg::DACSEQ_CTRL_OFS) && w_strb[0];
  wire wr_cfg = wr_go && (aw_addr == dacseq_pkg::DACSEQ_CFG_OFS) && w_strb[0];
  wire wr_div = wr_go && (aw_addr == dacseq_pkg::DACSEQ_DIV_OFS);
  // Mapped write offsets; any other answers with an error
  wire wr_hit = (aw_addr == dacseq_pkg::DACSEQ_CTRL_OFS) || (aw_addr == dacseq_pkg::DACSEQ_CFG_OFS) ||
                (aw_addr == dacseq_pkg::DACSEQ_DIV_OFS);
  // Configuration and dividers are locked while the device runs
  wire idle = (state == dacseq_pkg::DACSEQ_OFF);

  // Read decode
  wire [31:0] stat_word = {24'h000000, audio_valid, audio_mute, dac_reset_n, clk_run, 1'b0, state};
  // Mapped read offsets; any other answers with an error
  wire rd_hit = (s_axi_araddr == dacseq_pkg::DACSEQ_CTRL_OFS) || (s_axi_araddr == dacseq_pkg::DACSEQ_CFG_OFS) ||
                (s_axi_araddr == dacseq_pkg::DACSEQ_STAT_OFS) || (s_axi_araddr == dacseq_pkg::DACSEQ_DIV_OFS);
  // Read data select; unmapped offsets read as zero
  wire [31:0] rd_word = (s_axi_araddr == dacseq_pkg::DACSEQ_CTRL_OFS) ? {29'h0, por_mode, 2'h0} :
                        (s_axi_araddr == dacseq_pkg::DACSEQ_CFG_OFS) ? {29'h0, cfg} :
                        (s_axi_araddr == dacseq_pkg::DACSEQ_STAT_OFS) ? stat_word :
                        (s_axi_araddr == dacseq_pkg::DACSEQ_DIV_OFS) ? {16'h0, frame_half, bclk_half} :
                        32'h0;

  // Handshake outputs
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  // One read at a time: a new address waits while data stands
  assign s_axi_arready = !s_axi_rvalid;

  // Write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && !w_held) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dacseq_pkg::DACSEQ_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? dacseq_pkg::DACSEQ_RESP_OKAY : dacseq_pkg::DACSEQ_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= dacseq_pkg::DACSEQ_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? dacseq_pkg::DACSEQ_RESP_OKAY : dacseq_pkg::DACSEQ_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Software registers; mode, pins and ratios change only while off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_mode <= 1'b0;
      cfg <= dacseq_pkg::DACSEQ_CFG_RESET;
      bclk_half <= dacseq_pkg::DACSEQ_BCLK_HALF_RESET;
      frame_half <= dacseq_pkg::DACSEQ_FRAME_HALF_RESET;
      up_req <= 1'b0;
      down_req <= 1'b0;
    end else begin
      // Request bits act as one-cycle pulses
      up_req <= wr_ctrl && w_data[dacseq_pkg::DACSEQ_CTRL_UP_BIT];
      down_req <= wr_ctrl && w_data[dacseq_pkg::DACSEQ_CTRL_DOWN_BIT];
      if (wr_ctrl && idle) begin
        por_mode <= w_data[dacseq_pkg::DACSEQ_CTRL_PORMODE_BIT];
      end
      if (wr_cfg && idle) begin
        cfg <= w_data[2:0];
      end
      // A zero divider byte would stall the clocks, so it is ignored
      if (wr_div && idle && w_strb[0] && w_data[7:0] != 8'h00) begin
        bclk_half <= w_data[dacseq_pkg::DACSEQ_DIV_BCLK_LSB +: 8];
      end
      if (wr_div && idle && w_strb[1] && w_data[15:8] != 8'h00) begin
        frame_half <= w_data[dacseq_pkg::DACSEQ_DIV_FRAME_LSB +: 8];
      end
    end
  end

  // Master clock: half rate, stops only after a full high phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mclk <= 1'b0;
    end else if (clk_run || mclk) begin
      // Finishing a high phase keeps the last pulse full width
      mclk <= !mclk;
    end
  end

  // Bit and frame clocks derived synchronously from the master clock
  always_ff @(posedge aclk) begin
    if (!aresetn || !clk_run) begin
      // Dividers restart from zero on every clock start
      bdiv <= 8'h00;
      bclk <= 1'b0;
      fdiv <= 8'h00;
      fclk <= 1'b0;
    end else if (mclk_fall) begin
      bdiv <= bit_tick ? 8'h00 : bdiv + 8'h01;
      if (bit_tick) begin
        bclk <= !bclk;
      end
      // Frame divider advances once per bit clock period
      if (bclk_fall) begin
        fdiv <= frame_tick ? 8'h00 : fdiv + 8'h01;
      end
      if (frame_tick) begin
        fclk <= !fclk;
      end
    end
  end

  // Next-state decode
  always_comb begin
    next_state = state;
    unique case (state)
      dacseq_pkg::DACSEQ_OFF: begin
        // Idle until a power-up pulse
        if (up_req) begin
          next_state = dacseq_pkg::DACSEQ_SETTLE;
        end
      end
      dacseq_pkg::DACSEQ_SETTLE: begin
        // Configuration pins settle with clocks stopped
        if (timer == 32'(dacseq_pkg::DACSEQ_SETTLE_CYC - 1)) begin
          next_state = dacseq_pkg::DACSEQ_CLKRUN;
        end
      end
      dacseq_pkg::DACSEQ_CLKRUN: begin
        // Clocks run and lock while reset is still low, except in power-on-reset mode where it stays high
        if (timer == 32'(dacseq_pkg::DACSEQ_SETTLE_CYC - 1)) begin
          next_state = dacseq_pkg::DACSEQ_WAIT;
        end
      end
      dacseq_pkg::DACSEQ_WAIT: begin
        // Device starting; wait out the start-up latency
        if (timer == 32'(STARTUP_CYC - 1)) begin
          next_state = dacseq_pkg::DACSEQ_READY;
        end
      end
      dacseq_pkg::DACSEQ_READY: begin
        // Audio flows until a power-down pulse
        if (down_req) begin
          next_state = dacseq_pkg::DACSEQ_ZERO;
        end
      end
      dacseq_pkg::DACSEQ_ZERO: begin
        // Muted run of zero frames before shutdown
        if (frame_start && zero_cnt == dacseq_pkg::DACSEQ_ZERO_FRAMES) begin
          next_state = dacseq_pkg::DACSEQ_STOPCLK;
        end
      end
      dacseq_pkg::DACSEQ_STOPCLK: begin
        // Master clock ends after its high phase
        if (!mclk) begin
          next_state = dacseq_pkg::DACSEQ_OFF;
        end
      end
      default: begin
        // Unused encoding falls back to off
        next_state = dacseq_pkg::DACSEQ_OFF;
      end
    endcase
  end

  // Sequencer state and timers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= dacseq_pkg::DACSEQ_OFF;
      timer <= 32'h0;
      zero_cnt <= 14'h0;
    end else begin
      state <= next_state;
      // Timer restarts on every state change
      timer <= (next_state != state) ? 32'h0 : timer + 32'h1;
      // Zero-run frame counter, cleared outside the run
      if (state != dacseq_pkg::DACSEQ_ZERO) begin
        zero_cnt <= 14'h0;
      end else if (frame_start && zero_cnt != dacseq_pkg::DACSEQ_ZERO_FRAMES) begin
        zero_cnt <= zero_cnt + 14'h1;
      end
    end
  end

  // Pin outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_reset_n <= 1'b0;
      dac_cfg <= dacseq_pkg::DACSEQ_CFG_RESET;
      clk_run <= 1'b0;
      audio_mute <= 1'b1;
      audio_valid <= 1'b0;
    end else begin
      // Reset low while off; high constantly in power-on-reset mode
      dac_reset_n <= por_mode ? 1'b1 :
                     (next_state == dacseq_pkg::DACSEQ_WAIT || next_state == dacseq_pkg::DACSEQ_READY ||
                      next_state == dacseq_pkg::DACSEQ_ZERO || (next_state == dacseq_pkg::DACSEQ_STOPCLK && por_mode));
      // Configuration pins settle before any clock starts
      if (state == dacseq_pkg::DACSEQ_OFF && up_req) begin
        dac_cfg <= cfg;
      end
      // Clocks run from the clock-start state to the end of the zero run
      clk_run <= (next_state == dacseq_pkg::DACSEQ_CLKRUN) || (next_state == dacseq_pkg::DACSEQ_WAIT) ||
                 (next_state == dacseq_pkg::DACSEQ_READY) || (next_state == dacseq_pkg::DACSEQ_ZERO);
      // Source sends zeros whenever audio is not ready
      audio_mute <= (next_state != dacseq_pkg::DACSEQ_READY);
      audio_valid <= (next_state == dacseq_pkg::DACSEQ_READY);
    end
  end

  // Clock pin bundle
  assign dac_clk = '{master_clock: mclk, bit_clock: bclk, frame_clock: fclk};

endmodule
`default_nettype wire

// file: hw/dacseq_pkg.sv
/*
  Package for the audio DAC power sequencer (host side).
  Holds register offsets, field positions, reset values, timing counts,
  the sequencer state type and the packed pin bundles.
  Assumes a 50 MHz system clock and AXI4-Lite register access.
*/
package dacseq_pkg;

  // Register offsets (byte addresses, one aligned word each)
  localparam logic [3:0] DACSEQ_CTRL_OFS = 4'h0;
  localparam logic [3:0] DACSEQ_CFG_OFS = 4'h4;
  localparam logic [3:0] DACSEQ_STAT_OFS = 4'h8;
  localparam logic [3:0] DACSEQ_DIV_OFS = 4'hc;

  // Control register fields
  localparam int DACSEQ_CTRL_UP_BIT = 0;
  localparam int DACSEQ_CTRL_DOWN_BIT = 1;
  localparam int DACSEQ_CTRL_PORMODE_BIT = 2;

  // Configuration register fields
  localparam int DACSEQ_CFG_FMT_BIT = 0;
  localparam int DACSEQ_CFG_FS_BIT = 1;
  localparam int DACSEQ_CFG_DEM_BIT = 2;

  // Divider register fields: frame and bit clock ratios
  localparam int DACSEQ_DIV_BCLK_LSB = 0;
  localparam int DACSEQ_DIV_FRAME_LSB = 8;

  // Reset values
  localparam logic [2:0] DACSEQ_CFG_RESET = 3'h0;
  localparam logic [7:0] DACSEQ_BCLK_HALF_RESET = 8'h02;
  localparam logic [7:0] DACSEQ_FRAME_HALF_RESET = 8'h20;

  // Timing: clock rate and start-up latency
  localparam longint DACSEQ_CLK_HZ = 50000000;
  localparam longint DACSEQ_STARTUP_MS = 50;
  localparam longint DACSEQ_STARTUP_CYC = (DACSEQ_STARTUP_MS * DACSEQ_CLK_HZ) / 1000;
  localparam int DACSEQ_SETTLE_CYC = 16;
  localparam logic [13:0] DACSEQ_ZERO_FRAMES = 14'h2000;

  // AXI response codes
  localparam logic [1:0] DACSEQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] DACSEQ_RESP_SLVERR = 2'h2;

  // Sequencer states
  typedef enum logic [2:0] {
    DACSEQ_OFF,
    DACSEQ_SETTLE,
    DACSEQ_CLKRUN,
    DACSEQ_WAIT,
    DACSEQ_READY,
    DACSEQ_ZERO,
    DACSEQ_STOPCLK
  } dacseq_state_t;

  // Static configuration pins
  typedef struct packed {
    logic interface_format_select;
    logic fullscale_level_select;
    logic deemphasis_enable;
  } dacseq_cfg_t;

  // Clock pins toward the device
  typedef struct packed {
    logic master_clock;
    logic bit_clock;
    logic frame_clock;
  } dacseq_clk_t;

endpackage

// file: tb/dac_power_sequencing_bench.sv
/* Self-checking bench for the DAC power sequencer host.
   Drives AXI4-Lite at 50 MHz; the DAC model sits on the pin side. */
`timescale 1ns/1ps
`default_nettype none
module dac_power_sequencing_bench;
  localparam int STUP = 200; // Shortened start-up wait
  localparam int ZRUN = 8192 * 8; // Zero run cycles, frame of 8 cycles
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr; // rr: last read response
  logic dac_reset_n, audio_mute, audio_valid, analog_output, m;
  dacseq_pkg::dacseq_cfg_t dac_cfg; // Config pins
  dacseq_pkg::dacseq_clk_t dac_clk; // Clock pins
  int mismatches, check_count, n;
  time t;
  dacseq_host #(.STARTUP_CYC(STUP)) dacseq_host_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .dac_reset_n, .dac_cfg, .dac_clk, .audio_mute, .audio_valid);
  dacseq_dev_model #(.DEV_LAT(60)) dacseq_dev_model_i (.aclk, .reset_n(dac_reset_n), .clk_in(dac_clk),
    .analog_output);
  // Free-running 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic final_report();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Bound ran out
  task automatic hang();
    mismatches++;
    final_report();
  endtask
  // AXI write with expected response
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 100);
    s_axi_bready <= 1'b0;
    if (k >= 100) hang();
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  // AXI read
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 100);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k >= 100) hang();
  endtask
  // Read and compare
  task automatic rc(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
    chk({30'h0, rr}, {30'h0, dacseq_pkg::DACSEQ_RESP_OKAY});
  endtask
  // Wait for reset pin (s 0) or audio valid (s 1) high
  task automatic wsig(input int s, output int k);
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while ((s != 0 ? audio_valid : dac_reset_n) !== 1'b1 && k < 1000);
    if (k >= 1000) hang();
  endtask
  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hf;
    mismatches = 0;
    check_count = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(4'h8, 32'h40);
    chk({26'h0, dac_clk, dac_cfg}, 32'h0);
    rc(4'hc, 32'h2002);
    rc(4'h4, 32'h0);
    rd(4'h2, d);
    chk({30'h0, rr}, {30'h0, dacseq_pkg::DACSEQ_RESP_SLVERR});
    wr(4'h2, 32'h0, dacseq_pkg::DACSEQ_RESP_SLVERR);
    wr(4'hc, 32'h0, dacseq_pkg::DACSEQ_RESP_OKAY);
    rc(4'hc, 32'h2002);
    wr(4'hc, 32'h101, dacseq_pkg::DACSEQ_RESP_OKAY);
    wr(4'h4, 32'h5, dacseq_pkg::DACSEQ_RESP_OKAY);
    wr(4'h0, 32'h1, dacseq_pkg::DACSEQ_RESP_OKAY);
    wsig(0, n);
    chk({29'h0, dac_cfg}, 32'h5);
    m = dac_clk.master_clock;
    @(posedge aclk);
    chk({31'h0, dac_clk.master_clock ^ m}, 32'h1);
    wsig(1, n);
    chk({31'h0, n >= STUP - 1}, 32'h1);
    chk({30'h0, analog_output, audio_mute}, 32'h2);
    wr(4'h4, 32'h2, dacseq_pkg::DACSEQ_RESP_OKAY);
    rc(4'h4, 32'h5);
    t = $time;
    wr(4'h0, 32'h2, dacseq_pkg::DACSEQ_RESP_OKAY);
    repeat (2000) @(posedge aclk);
    chk({29'h0, dac_reset_n, audio_mute, audio_valid}, 32'h6);
    n = 0;
    do begin
      rd(4'h8, d);
      n++;
    end while (d[2:0] !== 3'h0 && n < 40000);
    if (n >= 40000) hang();
    chk({31'h0, ($time - t) >= ZRUN * 20}, 32'h1);
    chk({27'h0, dac_clk, dac_reset_n, analog_output}, 32'h0);
    wr(4'hc, 32'h101, dacseq_pkg::DACSEQ_RESP_OKAY);
    wr(4'h4, 32'h3, dacseq_pkg::DACSEQ_RESP_OKAY);
    wr(4'h0, 32'h4, dacseq_pkg::DACSEQ_RESP_OKAY);
    rc(4'h0, 32'h4);
    wr(4'h0, 32'h5, dacseq_pkg::DACSEQ_RESP_OKAY);
    wsig(1, n);
    chk({30'h0, dac_reset_n, analog_output}, 32'h3);
    chk({29'h0, dac_cfg}, 32'h3);
    wr(4'h0, 32'h6, dacseq_pkg::DACSEQ_RESP_OKAY);
    repeat (2000) @(posedge aclk);
    chk({29'h0, dac_reset_n, audio_mute, audio_valid}, 32'h6);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({26'h0, dac_clk, dac_reset_n, audio_mute, audio_valid}, 32'h2);
    final_report();
  end
endmodule
`default_nettype wire

// file: tb/dacseq_dev_model.sv
/* Behavioural model of the DAC as seen from its pins.
   Runs on the host's aclk; analog_output marks audio at the outputs. */
`timescale 1ns/1ps
`default_nettype none
module dacseq_dev_model #(
  parameter int DEV_LAT = 60
) (
  input wire logic aclk,
  input wire logic reset_n,
  input wire dacseq_pkg::dacseq_clk_t clk_in,
  output logic analog_output
);
  logic prev_m, prev_f; // Clock levels one cycle back
  logic [15:0] mcnt, ratio, lat; // Frame length, measured ratio, start-up count
  // Device state from reset, master clock and frame clock
  always @(posedge aclk) begin
    prev_m <= clk_in.master_clock;
    prev_f <= clk_in.frame_clock;
    if (!reset_n || clk_in.master_clock == prev_m) begin
      mcnt <= 16'h0;
      ratio <= 16'h0;
      lat <= 16'h0;
      analog_output <= 1'b0;
    end else if (clk_in.frame_clock && !prev_f) begin
      ratio <= mcnt;
      mcnt <= 16'h0;
    end else begin
      mcnt <= mcnt + 16'h1;
      if (ratio != 16'h0 && lat < 16'(DEV_LAT)) begin
        lat <= lat + 16'h1;
      end
      analog_output <= ratio != 16'h0 && lat == 16'(DEV_LAT);
    end
  end
endmodule
`default_nettype wire

// file: tb/dacseq_host_sva.sv
/* Port checker for the DAC power sequencer host.
   Bound into dacseq_host; assumes aclk and synchronous active-low aresetn. */
`timescale 1ns/1ps
`default_nettype none
module dacseq_host_sva #(
  parameter longint STARTUP_CYC = 100
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dac_reset_n,
  input wire dacseq_pkg::dacseq_cfg_t dac_cfg,
  input wire dacseq_pkg::dacseq_clk_t dac_clk,
  input wire logic audio_mute,
  input wire logic audio_valid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic prev_m; // Master clock one cycle back
  logic [31:0] run_cnt; // Cycles of unbroken master toggling
  logic [15:0] zero_cnt; // Frame starts seen while muted
  // Count master toggling and muted frame starts
  always_ff @(posedge aclk) begin
    prev_m <= aresetn & dac_clk.master_clock;
    if (!aresetn || dac_clk.master_clock == prev_m) begin
      run_cnt <= 32'h0;
    end else begin
      run_cnt <= run_cnt + 32'h1;
    end
    if (!aresetn || !audio_mute) begin
      zero_cnt <= 16'h0;
    end else if ($fell(dac_clk.frame_clock)) begin
      zero_cnt <= zero_cnt + 16'h1;
    end
  end
  // Master clock falls and is still low one cycle later
  sequence mclk_stop_s;
    $fell(dac_clk.master_clock) ##1 !dac_clk.master_clock;
  endsequence
  AST_RST_AFTER_CLK: assert property ($rose(dac_reset_n) |-> run_cnt == 32'h0 || run_cnt >= 32'h8)
    else $error("reset released before clocks ran");
  AST_MCLK_PULSE: assert property (dac_clk.master_clock |=> !dac_clk.master_clock)
    else $error("master clock high phase not one cycle");
  AST_CFG_HOLD: assert property (dac_clk.master_clock |-> $stable(dac_cfg))
    else $error("config pins moved while clocks ran");
  AST_VALID_LATENCY: assert property ($rose(audio_valid) |-> run_cnt >= STARTUP_CYC)
    else $error("audio valid before start-up wait");
  AST_VALID_UNMUTED: assert property (audio_valid |-> !audio_mute && dac_reset_n)
    else $error("audio valid while muted or in reset");
  AST_RST_AFTER_ZERO: assert property ($fell(dac_reset_n) |-> zero_cnt >= 16'h2000)
    else $error("reset lowered before zero run");
  AST_STOP_AFTER_ZERO: assert property (mclk_stop_s |-> zero_cnt >= 16'h2000)
    else $error("master clock stopped before zero run");
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_RD_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
endmodule
bind dacseq_host dacseq_host_sva #(.STARTUP_CYC(STARTUP_CYC)) dacseq_host_sva_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
  .dac_reset_n, .dac_cfg, .dac_clk, .audio_mute, .audio_valid);
`default_nettype wire
